//--- logic/flvr_regs.v
// Purpose: Forward input current limit and output voltage setting registers
// Assumes: A serial front end delivers decoded write-word and read-word commands
// Notes:   Scaled setpoints are driven to the regulation loops
`timescale 1ns/1ps
`include "flvr_defs.vh"

module flvr_regs (
   // Clock and reset
   input  wire                          clk,
   input  wire                          arst_n,
   // Command port
   input  wire                          wrStb,
   input  wire                          rdStb,
   input  wire [`FLVR_CMD_W-1:0]        cmdCode,
   input  wire [`FLVR_WORD_W-1:0]       wrData,
   // Command answer
   output reg                           ack_q,
   output reg                           nack_q,
   output reg                           rdValid_q,
   output reg  [`FLVR_WORD_W-1:0]       rdData_q,
   // Sense resistor strap pin, high for 10 milliohm
   input  wire                          input_sense_resistor,
   // Setpoints
   output reg  [`FLVR_CUR_W-1:0]        curCode_q,
   output reg  [`FLVR_VOLT_W-1:0]       voltCode_q,
   output reg  [`FLVR_CUR_MA_W-1:0]     curLimitMa_q,
   output reg  [`FLVR_VOLT_MV_W-1:0]    voltTargetMv_q
);

   wire                       hitCur;
   wire                       hitVolt;
   wire [`FLVR_CUR_W-1:0]     curField;
   wire [`FLVR_VOLT_W-1:0]    voltField;
   wire [`FLVR_CUR_W-1:0]     curStore;
   wire [`FLVR_VOLT_W-1:0]    voltStore;
   reg                        senseMeta_q;
   reg                        senseLow_q;
   reg  [`FLVR_CUR_MA_W-1:0]  curStep;
   reg  [`FLVR_WORD_W-1:0]    rdData_d;
   reg  [`FLVR_CUR_MA_W+`FLVR_CUR_W-1:0]   curProd;
   reg  [`FLVR_VOLT_MV_W+`FLVR_VOLT_W-1:0] voltProd;

   assign hitCur    = (cmdCode == `FLVR_CMD_CUR);
   assign hitVolt   = (cmdCode == `FLVR_CMD_VOLT);
   assign curField  = wrData[`FLVR_CUR_MSB:`FLVR_CUR_LSB];
   assign voltField = wrData[`FLVR_VOLT_MSB:`FLVR_VOLT_LSB];

   // Current limit field
   flvr_field #(
      .W        (`FLVR_CUR_W),
      .MAX_CODE (`FLVR_CUR_MAX_CODE),
      .RST_CODE (`FLVR_CUR_RST_CODE),
      .IGN_ZERO (0)
   ) uCur (
      .clk      (clk),
      .arst_n   (arst_n),
      .wrEn     (wrStb && hitCur),
      .wrField  (curField),
      .code_q   (curStore)
   );

   // Voltage target field
   flvr_field #(
      .W        (`FLVR_VOLT_W),
      .MAX_CODE (`FLVR_VOLT_MAX_CODE),
      .RST_CODE (`FLVR_VOLT_RST_CODE),
      .IGN_ZERO (1)
   ) uVolt (
      .clk      (clk),
      .arst_n   (arst_n),
      .wrEn     (wrStb && hitVolt),
      .wrField  (voltField),
      .code_q   (voltStore)
   );

   // Strap synchroniser
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         senseMeta_q <= 1'b0;
         senseLow_q  <= 1'b0;
      end else begin
         senseMeta_q <= input_sense_resistor;
         senseLow_q  <= senseMeta_q;
      end
   end

   // Scaling and readback
   always @* begin
      curStep  = senseLow_q ? `FLVR_CUR_STEP_LO_MA : `FLVR_CUR_STEP_MA;
      curProd  = curStore * curStep;
      voltProd = voltStore * `FLVR_VOLT_STEP_MV;
      rdData_d = {`FLVR_WORD_W{1'b0}};
      if (hitCur) begin
         rdData_d[`FLVR_CUR_MSB:`FLVR_CUR_LSB] = curStore;
      end else if (hitVolt) begin
         rdData_d[`FLVR_VOLT_MSB:`FLVR_VOLT_LSB] = voltStore;
      end
   end

   // Answers and setpoint outputs
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_q          <= 1'b0;
         nack_q         <= 1'b0;
         rdValid_q      <= 1'b0;
         rdData_q       <= {`FLVR_WORD_W{1'b0}};
         curCode_q      <= `FLVR_CUR_RST_CODE;
         voltCode_q     <= `FLVR_VOLT_RST_CODE;
         curLimitMa_q   <= {`FLVR_CUR_MA_W{1'b0}};
         voltTargetMv_q <= {`FLVR_VOLT_MV_W{1'b0}};
      end else begin
         ack_q          <= (wrStb || rdStb) && (hitCur || hitVolt);
         nack_q         <= (wrStb || rdStb) && !(hitCur || hitVolt);
         rdValid_q      <= rdStb && !wrStb && (hitCur || hitVolt);
         if (rdStb && !wrStb) begin
            rdData_q    <= rdData_d;
         end
         curCode_q      <= curStore;
         voltCode_q     <= voltStore;
         curLimitMa_q   <= curProd[`FLVR_CUR_MA_W-1:0];
         voltTargetMv_q <= voltProd[`FLVR_VOLT_MV_W-1:0];
      end
   end

endmodule // flvr_regs

//--- include/flvr_defs.vh
// Purpose: Constants for the forward limit and voltage setting registers
// Assumes: Included by bare name from the design files
// Notes:   Field positions, clamps, reset codes and step weights
`ifndef FLVR_DEFS_VH
`define FLVR_DEFS_VH

// Command codes
`define FLVR_CMD_VOLT       8'h15
`define FLVR_CMD_CUR        8'h3F

// Input current field
`define FLVR_CUR_W          11
`define FLVR_CUR_LSB        2
`define FLVR_CUR_MSB        12
`define FLVR_CUR_MAX_CODE   11'h5F0
`define FLVR_CUR_RST_CODE   11'h000
`define FLVR_CUR_STEP_MA    14'h0004
`define FLVR_CUR_STEP_LO_MA 14'h0008
`define FLVR_CUR_MA_W       14

// Output voltage field
`define FLVR_VOLT_W         12
`define FLVR_VOLT_LSB       3
`define FLVR_VOLT_MSB       14
`define FLVR_VOLT_MAX_CODE  12'h800
`define FLVR_VOLT_RST_CODE  12'h20C
`define FLVR_VOLT_STEP_MV   16'h000C
`define FLVR_VOLT_MV_W      16

`define FLVR_WORD_W         16
`define FLVR_CMD_W          8

`endif

//--- logic/flvr_field.v
// Purpose: One masked, clamped setting field
// Assumes: Write strobe and data from the same clock domain
// Notes:   Optional ignore of a zero write
`timescale 1ns/1ps

module flvr_field #(
   parameter                W        = 11,
   parameter [W-1:0]        MAX_CODE = {W{1'b1}},
   parameter [W-1:0]        RST_CODE = {W{1'b0}},
   parameter                IGN_ZERO = 0
) (
   // Clock and reset
   input  wire              clk,
   input  wire              arst_n,
   // Write side
   input  wire              wrEn,
   input  wire [W-1:0]      wrField,
   // Stored code
   output reg  [W-1:0]      code_q
);

   reg  [W-1:0] code_d;

   always @* begin
      code_d = code_q;
      if (wrEn) begin
         if ((IGN_ZERO != 0) && (wrField == {W{1'b0}})) begin
            code_d = code_q;
         end else if (wrField > MAX_CODE) begin
            code_d = MAX_CODE;
         end else begin
            code_d = wrField;
         end
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         code_q <= RST_CODE;
      end else begin
         code_q <= code_d;
      end
   end

endmodule // flvr_field

//--- verification/flvr_regs_sva.sv
// Purpose: Port checks on flvr_regs
// Assumes: One clock
// Notes: Bound below
`timescale 1ns/1ps
module flvr_sva (
   input wire        clk, arst_n, wrStb, rdStb, ack_q, nack_q, rdValid_q,
   input wire [7:0]  cmdCode,
   input wire [15:0] wrData, rdData_q, voltTargetMv_q,
   input wire [10:0] curCode_q,
   input wire [11:0] voltCode_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire kn = cmdCode == 8'h15 || cmdCode == 8'h3F;
   wire cw = wrStb && cmdCode == 8'h3F;
   wire vw = wrStb && cmdCode == 8'h15;
   sequence cwr; cw && wrData[12:2] <= 11'h5F0 ##1 !wrStb; endsequence
   sequence vzr; vw && wrData[14:3] == 12'h000 ##1 !wrStb; endsequence
   a_ack_known: assert property ((wrStb || rdStb) && kn |=> ack_q && !nack_q)
      else $error("no ack");
   a_nack_other: assert property ((wrStb || rdStb) && !kn |=> nack_q && !ack_q)
      else $error("no nack");
   a_cur_mask: assert property (cwr |=> curCode_q == $past(wrData[12:2], 2))
      else $error("bad current field");
   a_cur_clamp: assert property (cw && wrData[12:2] > 11'h5F0 |=> ##1 curCode_q == 11'h5F0)
      else $error("no current clamp");
   a_volt_clamp: assert property (vw && wrData[14:3] > 12'h800 |=> ##1 voltCode_q == 12'h800)
      else $error("no voltage clamp");
   a_volt_zero: assert property (vzr |=> $stable(voltCode_q))
      else $error("zero write stored");
   a_volt_scale: assert property ($past(arst_n) |-> voltTargetMv_q == voltCode_q * 16'd12)
      else $error("bad voltage scale");
   a_rd_unused: assert property (rdValid_q |-> rdData_q[15] == 1'b0 && rdData_q[1:0] == 2'b00)
      else $error("unused bits set");
   a_rd_valid: assert property (rdStb && !wrStb && kn |=> rdValid_q)
      else $error("no read valid");
endmodule // flvr_sva
bind flvr_regs flvr_sva chk (.clk, .arst_n, .wrStb, .rdStb, .ack_q, .nack_q, .rdValid_q,
   .cmdCode, .wrData, .rdData_q, .voltTargetMv_q, .curCode_q, .voltCode_q);

//--- verification/flvr_host.sv
// Purpose: Host command model
// Assumes: One-cycle strobes
// Notes: Idle lines show inverted data
`timescale 1ns/1ps
module flvr_host (
   input wire        clk, ack_q, nack_q,
   output reg        wrStb = 1'b0, rdStb = 1'b0,
   output reg [7:0]  cmdCode = 8'h00,
   output reg [15:0] wrData = 16'h0000
);
   task xfer(input w, input [7:0] c, input [15:0] d, output ok);
      integer n;
      begin
         @(posedge clk) #1;
         {wrStb, rdStb, cmdCode, wrData} = {w, !w, c, d};
         @(posedge clk) #1;
         {wrStb, rdStb, cmdCode, wrData} = {2'b00, ~c, ~d};
         for (n = 0; n < 4 && !(ack_q || nack_q); n = n + 1) @(posedge clk) #1;
         ok = ack_q;
      end
   endtask
endmodule // flvr_host

//--- verification/tb_top.sv
// Purpose: Register bank bench
// Assumes: 40 MHz clock
// Notes: Host model drives commands
`timescale 1ns/1ps
module tb_top;
   reg         clk = 1'b0, arst_n = 1'b0, pin = 1'b0, ok;
   wire        wrStb, rdStb, ack_q, nack_q, rdv;
   wire [7:0]  cmdCode;
   wire [15:0] wrData, rdData_q, mv;
   wire [13:0] ma;
   integer     bad_count = 0, checked = 0;
   always #12.5 clk = ~clk;
   flvr_host HOST (.clk, .ack_q, .nack_q, .wrStb, .rdStb, .cmdCode, .wrData);
   flvr_regs DUT (.clk, .arst_n, .wrStb, .rdStb, .cmdCode, .wrData, .ack_q, .nack_q,
      .rdValid_q(rdv), .rdData_q, .input_sense_resistor(pin), .curCode_q(), .voltCode_q(),
      .curLimitMa_q(ma), .voltTargetMv_q(mv));
   task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
      begin
         checked = checked + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task wr(input [7:0] c, input [15:0] d);
      begin
         HOST.xfer(1'b1, c, d, ok);
         chk("ack", 16'h0001, {15'h0000, ok});
      end
   endtask
   task rd(input [7:0] c, input [15:0] e);
      begin
         HOST.xfer(1'b0, c, 16'h0000, ok);
         chk("rdAck", {15'h0000, c == 8'h15 || c == 8'h3F}, {15'h0000, ok});
         chk("rdValid", {15'h0000, c == 8'h15 || c == 8'h3F}, {15'h0000, rdv});
         chk("rdData", e, rdData_q);
      end
   endtask
   task complete_run;
      begin
         $display("checked %0d bad_count %0d", checked, bad_count);
         if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      #100000;
      bad_count = bad_count + 1;
      complete_run;
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 arst_n = 1'b1;
      rd(8'h15, 16'h1060);
      chk("mv", 16'h1890, mv);
      wr(8'h3F, 16'hFFFF);
      rd(8'h3F, 16'h17C0);
      chk("ma", 16'h17C0, {2'b00, ma});
      pin = 1'b1;
      repeat (4) @(posedge clk) #1;
      chk("ma", 16'h2F80, {2'b00, ma});
      wr(8'h3F, 16'h0006);
      rd(8'h3F, 16'h0004);
      chk("ma", 16'h0008, {2'b00, ma});
      wr(8'h15, 16'hFFFF);
      rd(8'h15, 16'h4000);
      chk("mv", 16'h6000, mv);
      wr(8'h15, 16'h8007);
      rd(8'h15, 16'h4000);
      wr(8'h15, 16'h0018);
      rd(8'h15, 16'h0018);
      chk("mv", 16'h0024, mv);
      HOST.xfer(1'b1, 8'h20, 16'h0018, ok);
      chk("nack", 16'h0000, {15'h0000, ok});
      chk("nackPin", 16'h0001, {15'h0000, nack_q});
      rd(8'h20, 16'h0000);
      @(posedge clk) #1 arst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 arst_n = 1'b1;
      rd(8'h15, 16'h1060);
      chk("mv", 16'h1890, mv);
      rd(8'h3F, 16'h0000);
      complete_run;
   end
endmodule // tb_top
